// *** verilog/hcb_pkg.sv ***
// package: constants and types shared by the host bus bridge ends
// Functional notes
// - route cycles to DRAM or PCI by address
// - device drives address while other master owns
// - processor supplies eight active-low lane enables
// - processor strobe marks first clock of cycle
// - memory/IO qualifier low means I/O cycle
// - write/read input normally, driven during PCI cycles
// - processor drives data/code qualifier each cycle
// - burst ready asserted per valid data clock
// - hold request answered after current cycle ends
// - hold acknowledge held high whole hold period
// - processor flags snoop hit on modified line
// - address-20 mask inactive through reset
// - cache enable low only for cacheable cycles
// - processor cacheability indication gates L1 fill
// - inquire drives snoop address with strobe
// - next-address one-clock pulse; new cycle two later
// - active-high processor reset output
// - separate init output acts as soft reset
// - system-management interrupt output, active low
// - processor acknowledges system management, active low
// - stop-clock request output, active low
package hcb_pkg;
    localparam int ADDR_W = 29;             // address bits 31:3
    localparam int LANE_W = 8;
    localparam logic [28:0] DRAM_TOP_RESET = 29'h01FF_FFFF; // at or below this: DRAM (256 MB default)
    localparam int BURST_LEN = 4;            // beats of a burst
    localparam logic [2:0] BEAT_LAST = 3'h3;
    localparam logic [1:0] NA_GAP = 2'h2;    // clocks from next-address to new strobe
    typedef enum logic [1:0] {
        HCB_TGT_NONE,
        HCB_TGT_DRAM,
        HCB_TGT_PCI,
        HCB_TGT_IO
    } hcb_target_type;
endpackage

// *** verilog/hcb_if.sv ***
// interface: processor local bus between bridge and processor end
`timescale 1ns/100ps
`default_nettype none
interface hcb_if;
    logic [28:0] addr_cpu;        // address driven by processor
    logic        addr_cpu_oe;
    logic [28:0] addr_dev;        // address driven by bridge
    logic        addr_dev_oe;
    logic [7:0]  lane_en_n;
    logic        cycle_strobe_n;
    logic        mem_io;
    logic        wr_cpu;
    logic        wr_cpu_oe;
    logic        wr_dev;
    logic        wr_dev_oe;
    logic        data_code;
    logic        cache_ind_n;
    logic        burst_rdy_n;
    logic        next_cycle_ok_n;
    logic        l1_cacheable_n;
    logic        inquire_strobe_n;
    logic        snoop_hit_dirty_n;
    logic        bus_hold_req;
    logic        bus_hold_ack;
    logic        addr20_mask_n;
    logic        proc_reset;
    logic        proc_init;
    logic        sysmgmt_irq_n;
    logic        sysmgmt_active_n;
    logic        clock_stop_req_n;
    modport dev (
        input  addr_cpu, addr_cpu_oe, lane_en_n, cycle_strobe_n, mem_io, wr_cpu, wr_cpu_oe,
        input  data_code, cache_ind_n, snoop_hit_dirty_n, bus_hold_ack, sysmgmt_active_n,
        output addr_dev, addr_dev_oe, wr_dev, wr_dev_oe, burst_rdy_n, next_cycle_ok_n,
        output l1_cacheable_n, inquire_strobe_n, bus_hold_req, addr20_mask_n, proc_reset,
        output proc_init, sysmgmt_irq_n, clock_stop_req_n
    );
    modport cpu (
        output addr_cpu, addr_cpu_oe, lane_en_n, cycle_strobe_n, mem_io, wr_cpu, wr_cpu_oe,
        output data_code, cache_ind_n, snoop_hit_dirty_n, bus_hold_ack, sysmgmt_active_n,
        input  addr_dev, addr_dev_oe, wr_dev, wr_dev_oe, burst_rdy_n, next_cycle_ok_n,
        input  l1_cacheable_n, inquire_strobe_n, bus_hold_req, addr20_mask_n, proc_reset,
        input  proc_init, sysmgmt_irq_n, clock_stop_req_n
    );
endinterface
`default_nettype wire

// *** verilog/hcb_bridge.sv ***
// module: bridge end of the processor bus (decode, handshakes, hold, sideband)
`timescale 1ns/100ps
`default_nettype none
module hcb_bridge (
    input  wire logic                   CLK_IN,
    input  wire logic                   RST_N_IN,
    hcb_if.dev                          bus,
    input  wire logic [28:0]            DRAM_TOP_IN,
    input  wire logic                   PCI_REQ_IN,
    input  wire logic [28:0]            PCI_ADDR_IN,
    input  wire logic                   PCI_WRITE_IN,
    input  wire logic                   SNOOP_REQ_IN,
    input  wire logic [28:0]            SNOOP_ADDR_IN,
    input  wire logic                   A20_MASK_IN,
    input  wire logic                   PROC_RESET_IN,
    input  wire logic                   PROC_INIT_IN,
    input  wire logic                   SMI_EVENT_IN,
    input  wire logic                   STOP_CLOCK_IN,
    output logic                        CYCLE_VALID_OUT,
    output hcb_pkg::hcb_target_type     CYCLE_TARGET_OUT,
    output logic [28:0]                 CYCLE_ADDR_OUT,
    output logic                        CYCLE_WRITE_OUT,
    output logic                        CYCLE_CODE_OUT,
    output logic [7:0]                  CYCLE_LANES_OUT,
    output logic                        PCI_GRANT_OUT,
    output logic                        SNOOP_DIRTY_OUT,
    output logic                        SMM_ACTIVE_OUT
);
    import hcb_pkg::*;

    typedef enum {ST_IDLE, ST_BURST, ST_HOLD_WAIT, ST_HELD} hcb_state_type;

    // two-flop sync of processor pins
    logic [9:0] s1_reg, s2_reg;
    logic [28:0] a1_reg, a2_reg;
    logic [7:0] l1_reg, l2_reg;
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s1_reg <= 10'h3FF;
            s2_reg <= 10'h3FF;
            a1_reg <= 29'h0;
            a2_reg <= 29'h0;
            l1_reg <= 8'hFF;
            l2_reg <= 8'hFF;
        end else begin
            s1_reg <= {bus.cycle_strobe_n, bus.mem_io, bus.wr_cpu, bus.data_code,
                       bus.cache_ind_n, bus.snoop_hit_dirty_n, ~bus.bus_hold_ack,
                       bus.sysmgmt_active_n, 2'h3};
            s2_reg <= s1_reg;
            a1_reg <= bus.addr_cpu;
            a2_reg <= a1_reg;
            l1_reg <= bus.lane_en_n;
            l2_reg <= l1_reg;
        end
    end
    logic strobe_n, mem_cyc, wr_in, code_n, cache_n, hit_n, hold_ack, smm_n;
    assign strobe_n = s2_reg[9];
    assign mem_cyc  = s2_reg[8];
    assign wr_in    = s2_reg[7];
    assign code_n   = s2_reg[6];
    assign cache_n  = s2_reg[5];
    assign hit_n    = s2_reg[4];
    assign hold_ack = ~s2_reg[3];
    assign smm_n    = s2_reg[2];

    // range decode used for routing and cacheability
    function automatic hcb_target_type decode(input logic mem, input logic [28:0] a,
                                              input logic [28:0] top);
        if (!mem)
            decode = HCB_TGT_IO;
        else if (a <= top)
            decode = HCB_TGT_DRAM;
        else
            decode = HCB_TGT_PCI;
    endfunction

    hcb_state_type st_reg, st_next;
    logic [2:0] beat_reg, beat_next;
    logic vld_reg, vld_next, burst_rdy_n_reg, burst_rdy_n_next, na_reg, na_next, ken_reg, ken_next;
    logic hold_reg, hold_next, grant_reg, grant_next, inquire_strobe_n_reg, inquire_strobe_n_next;
    logic aoe_reg, aoe_next, woe_reg, woe_next, wr_reg, wr_next;
    logic [28:0] aout_reg, aout_next, caddr_reg, caddr_next;
    hcb_target_type tgt_reg, tgt_next;
    logic cwr_reg, cwr_next, ccode_reg, ccode_next, dirty_reg, dirty_next;
    logic [7:0] lanes_reg, lanes_next;

    // next-state logic of the bus engine
    always_comb begin
        st_next = st_reg;
        beat_next = beat_reg;
        vld_next = 1'b0;
        burst_rdy_n_next = 1'b1;
        na_next = 1'b1;
        ken_next = ken_reg;
        hold_next = hold_reg;
        grant_next = grant_reg;
        inquire_strobe_n_next = 1'b1;
        aoe_next = aoe_reg;
        woe_next = woe_reg;
        wr_next = wr_reg;
        aout_next = aout_reg;
        caddr_next = caddr_reg;
        tgt_next = tgt_reg;
        cwr_next = cwr_reg;
        ccode_next = ccode_reg;
        lanes_next = lanes_reg;
        dirty_next = ~hit_n; // snoop hit report
        case (st_reg)
            ST_IDLE: begin
                if (!strobe_n) begin
                    tgt_next = decode(mem_cyc, a2_reg, DRAM_TOP_IN);
                    caddr_next = a2_reg;
                    cwr_next = wr_in;
                    ccode_next = ~code_n;
                    lanes_next = l2_reg;
                    vld_next = 1'b1;
                    // cacheable only for DRAM reads; processor qualifier
                    ken_next = !(decode(mem_cyc, a2_reg, DRAM_TOP_IN) == HCB_TGT_DRAM
                                 && !wr_in && !cache_n);
                    beat_next = 3'h0;
                    st_next = ST_BURST;
                end else if ((PCI_REQ_IN || SNOOP_REQ_IN) && !hold_ack) begin
                    // request the bus, only once the last ack has gone
                    hold_next = 1'b1;
                    st_next = ST_HOLD_WAIT;
                end
            end
            ST_BURST: begin
                burst_rdy_n_next = 1'b0;
                beat_next = beat_reg + 3'h1;
                if (beat_reg == BEAT_LAST - 3'h2)
                    na_next = 1'b0;
                // last beat still carries ready, so a burst gives four beats
                if (beat_reg == BEAT_LAST) begin
                    ken_next = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            ST_HOLD_WAIT: begin
                if (hold_ack) begin
                    st_next = ST_HELD;
                    if (SNOOP_REQ_IN) begin
                        aout_next = SNOOP_ADDR_IN;
                        aoe_next = 1'b1;
                        inquire_strobe_n_next = 1'b0;
                    end else begin
                        aout_next = PCI_ADDR_IN;
                        aoe_next = 1'b1;
                        wr_next = PCI_WRITE_IN;
                        woe_next = 1'b1;
                        grant_next = 1'b1;
                    end
                end
            end
            ST_HELD: begin
                if (grant_reg) begin
                    aout_next = PCI_ADDR_IN;
                    wr_next = PCI_WRITE_IN;
                end
                if (!PCI_REQ_IN && !SNOOP_REQ_IN) begin
                    hold_next = 1'b0;
                    grant_next = 1'b0;
                    aoe_next = 1'b0;
                    woe_next = 1'b0;
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    // register all on rising edge, idle in reset
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_reg <= ST_IDLE;
            beat_reg <= 3'h0;
            vld_reg <= 1'b0;
            burst_rdy_n_reg <= 1'b1;
            na_reg <= 1'b1;
            ken_reg <= 1'b1;
            hold_reg <= 1'b0;
            grant_reg <= 1'b0;
            inquire_strobe_n_reg <= 1'b1;
            aoe_reg <= 1'b0;
            woe_reg <= 1'b0;
            wr_reg <= 1'b0;
            aout_reg <= 29'h0;
            caddr_reg <= 29'h0;
            tgt_reg <= HCB_TGT_NONE;
            cwr_reg <= 1'b0;
            ccode_reg <= 1'b0;
            lanes_reg <= 8'hFF;
            dirty_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            beat_reg <= beat_next;
            vld_reg <= vld_next;
            burst_rdy_n_reg <= burst_rdy_n_next;
            na_reg <= na_next;
            ken_reg <= ken_next;
            hold_reg <= hold_next;
            grant_reg <= grant_next;
            inquire_strobe_n_reg <= inquire_strobe_n_next;
            aoe_reg <= aoe_next;
            woe_reg <= woe_next;
            wr_reg <= wr_next;
            aout_reg <= aout_next;
            caddr_reg <= caddr_next;
            tgt_reg <= tgt_next;
            cwr_reg <= cwr_next;
            ccode_reg <= ccode_next;
            lanes_reg <= lanes_next;
            dirty_reg <= dirty_next;
        end
    end

    // sideband pins, registered
    logic a20_reg, rst_reg, init_reg, smi_reg, stp_reg, smm_reg;
    logic a20_next, rst_next, init_next, smi_next, stp_next, smm_next;
    always_comb begin
        a20_next = !(A20_MASK_IN && !PROC_RESET_IN);
        rst_next = PROC_RESET_IN;
        init_next = PROC_INIT_IN;
        smi_next = ~SMI_EVENT_IN;
        stp_next = ~STOP_CLOCK_IN;
        smm_next = ~smm_n;
    end
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            a20_reg <= 1'b1;
            rst_reg <= 1'b0;
            init_reg <= 1'b0;
            smi_reg <= 1'b1;
            stp_reg <= 1'b1;
            smm_reg <= 1'b0;
        end else begin
            a20_reg <= a20_next;
            rst_reg <= rst_next;
            init_reg <= init_next;
            smi_reg <= smi_next;
            stp_reg <= stp_next;
            smm_reg <= smm_next;
        end
    end

    // pin and user outputs from flops
    assign bus.addr_dev = aout_reg;
    assign bus.addr_dev_oe = aoe_reg;
    assign bus.wr_dev = wr_reg;
    assign bus.wr_dev_oe = woe_reg;
    assign bus.burst_rdy_n = burst_rdy_n_reg;
    assign bus.next_cycle_ok_n = na_reg;
    assign bus.l1_cacheable_n = ken_reg;
    assign bus.inquire_strobe_n = inquire_strobe_n_reg;
    assign bus.bus_hold_req = hold_reg;
    assign bus.addr20_mask_n = a20_reg;
    assign bus.proc_reset = rst_reg;
    assign bus.proc_init = init_reg;
    assign bus.sysmgmt_irq_n = smi_reg;
    assign bus.clock_stop_req_n = stp_reg;
    assign CYCLE_VALID_OUT = vld_reg;
    assign CYCLE_TARGET_OUT = tgt_reg;
    assign CYCLE_ADDR_OUT = caddr_reg;
    assign CYCLE_WRITE_OUT = cwr_reg;
    assign CYCLE_CODE_OUT = ccode_reg;
    assign CYCLE_LANES_OUT = lanes_reg;
    assign PCI_GRANT_OUT = grant_reg;
    assign SNOOP_DIRTY_OUT = dirty_reg;
    assign SMM_ACTIVE_OUT = smm_reg;
endmodule
`default_nettype wire

// *** verilog/hcb_proc.sv ***
// module: processor end of the local bus (issues cycles, answers hold)
`timescale 1ns/100ps
`default_nettype none
module hcb_proc (
    input  wire logic          CLK_IN,
    input  wire logic          RST_N_IN,
    hcb_if.cpu                 bus,
    input  wire logic          REQ_IN,
    input  wire logic [28:0]   REQ_ADDR_IN,
    input  wire logic [7:0]    REQ_LANES_IN,
    input  wire logic          REQ_MEM_IN,
    input  wire logic          REQ_WRITE_IN,
    input  wire logic          REQ_CODE_IN,
    input  wire logic          REQ_CACHE_IN,
    input  wire logic          SNOOP_DIRTY_IN,
    input  wire logic          SMM_IN,
    output logic               REQ_READY_OUT,
    output logic               BEAT_OUT,
    output logic               HELD_OUT,
    output logic               RESET_SEEN_OUT
);
    import hcb_pkg::*;

    typedef enum {PS_IDLE, PS_BUSY, PS_HELD} hcb_pstate_type;

    // two-flop sync of bridge pins
    logic [4:0] s1_reg, s2_reg;
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s1_reg <= 5'h0F;
            s2_reg <= 5'h0F;
        end else begin
            s1_reg <= {bus.bus_hold_req, bus.burst_rdy_n, bus.next_cycle_ok_n,
                       bus.inquire_strobe_n, ~bus.proc_reset};
            s2_reg <= s1_reg;
        end
    end
    logic hold_req, burst_rdy_n_n, na_n, prst;
    assign hold_req = s2_reg[4];
    assign burst_rdy_n_n = s2_reg[3];
    assign na_n = s2_reg[2];
    assign prst = ~s2_reg[0];

    hcb_pstate_type st_reg, st_next;
    logic ads_reg, ads_next, ack_reg, ack_next, oe_reg, oe_next, beat_reg, beat_next;
    logic [1:0] na_cnt_reg, na_cnt_next;
    logic [28:0] a_reg, a_next;
    logic [7:0] l_reg, l_next;
    logic m_reg, m_next, w_reg, w_next, c_reg, c_next, k_reg, k_next, hit_reg, hit_next;

    // processor bus sequencing
    always_comb begin
        st_next = st_reg;
        ads_next = 1'b1;
        ack_next = ack_reg;
        oe_next = oe_reg;
        beat_next = ~burst_rdy_n_n;
        na_cnt_next = (na_cnt_reg != 2'h0) ? na_cnt_reg - 2'h1 : 2'h0;
        a_next = a_reg;
        l_next = l_reg;
        m_next = m_reg;
        w_next = w_reg;
        c_next = c_reg;
        k_next = k_reg;
        hit_next = 1'b1;
        // start pending cycle two clocks after next-address
        if (!na_n)
            na_cnt_next = NA_GAP;
        case (st_reg)
            PS_IDLE: begin
                if (hold_req) begin
                    // grant only between cycles; ack held
                    ack_next = 1'b1;
                    oe_next = 1'b0;
                    st_next = PS_HELD;
                end else if (REQ_IN) begin
                    ads_next = 1'b0;
                    oe_next = 1'b1;
                    a_next = REQ_ADDR_IN;
                    l_next = REQ_LANES_IN;
                    m_next = REQ_MEM_IN;
                    w_next = REQ_WRITE_IN;
                    c_next = ~REQ_CODE_IN;
                    k_next = ~REQ_CACHE_IN;
                    st_next = PS_BUSY;
                end
            end
            PS_BUSY: begin
                if (na_cnt_reg == 2'h1 || (!burst_rdy_n_n && beat_reg && !REQ_IN))
                    st_next = PS_IDLE;
            end
            PS_HELD: begin
                hit_next = ~SNOOP_DIRTY_IN;
                if (!hold_req) begin
                    ack_next = 1'b0;
                    st_next = PS_IDLE;
                end
            end
            default: st_next = PS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_reg <= PS_IDLE;
            ads_reg <= 1'b1;
            ack_reg <= 1'b0;
            oe_reg <= 1'b0;
            beat_reg <= 1'b0;
            na_cnt_reg <= 2'h0;
            a_reg <= 29'h0;
            l_reg <= 8'hFF;
            m_reg <= 1'b1;
            w_reg <= 1'b0;
            c_reg <= 1'b1;
            k_reg <= 1'b1;
            hit_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            ads_reg <= ads_next;
            ack_reg <= ack_next;
            oe_reg <= oe_next;
            beat_reg <= beat_next;
            na_cnt_reg <= na_cnt_next;
            a_reg <= a_next;
            l_reg <= l_next;
            m_reg <= m_next;
            w_reg <= w_next;
            c_reg <= c_next;
            k_reg <= k_next;
            hit_reg <= hit_next;
        end
    end

    // pin drives
    assign bus.addr_cpu = a_reg;
    assign bus.addr_cpu_oe = oe_reg;
    assign bus.lane_en_n = l_reg;
    assign bus.cycle_strobe_n = ads_reg;
    assign bus.mem_io = m_reg;
    assign bus.wr_cpu = w_reg;
    assign bus.wr_cpu_oe = oe_reg;
    assign bus.data_code = c_reg;
    assign bus.cache_ind_n = k_reg;
    assign bus.snoop_hit_dirty_n = hit_reg;
    assign bus.bus_hold_ack = ack_reg;
    assign bus.sysmgmt_active_n = ~SMM_IN;
    assign REQ_READY_OUT = (st_reg == PS_IDLE) && ads_reg;
    assign BEAT_OUT = beat_reg;
    assign HELD_OUT = ack_reg;
    assign RESET_SEEN_OUT = prst;
endmodule
`default_nettype wire

// *** tb/hcb_props.sv ***
// checker: timing relations on the processor local bus
`timescale 1ns/100ps
`default_nettype none
module hcb_props (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic cycle_strobe_n,
    input wire logic mem_io,
    input wire logic cache_ind_n,
    input wire logic burst_rdy_n,
    input wire logic next_cycle_ok_n,
    input wire logic l1_cacheable_n,
    input wire logic inquire_strobe_n,
    input wire logic bus_hold_req,
    input wire logic bus_hold_ack,
    input wire logic addr_dev_oe,
    input wire logic wr_dev_oe,
    input wire logic addr20_mask_n,
    input wire logic proc_reset
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // four beats of valid data, then ready drops
    sequence burst_beats;
        (!burst_rdy_n) [*4] ##1 burst_rdy_n;
    endsequence
    burst_len_a: assert property ($fell(burst_rdy_n) |-> burst_beats)
        else $error("burst ready not four beats");
    burst_cause_a: assert property ($fell(burst_rdy_n) |-> $past(!cycle_strobe_n, 4))
        else $error("burst without strobe four clocks before");
    na_pulse_a: assert property (!next_cycle_ok_n |=> next_cycle_ok_n)
        else $error("next address longer than one clock");
    na_place_a: assert property ($fell(burst_rdy_n) |-> ##1 !next_cycle_ok_n)
        else $error("next address not at second beat");
    ken_cause_a: assert property ($fell(l1_cacheable_n)
        |-> $past(!cycle_strobe_n && !cache_ind_n && mem_io, 3))
        else $error("cache enable without cacheable memory cycle");
    addr_drive_a: assert property ($rose(addr_dev_oe) |-> bus_hold_ack && $past(bus_hold_ack))
        else $error("address driven before hold acknowledge");
    wr_drive_a: assert property (wr_dev_oe |-> addr_dev_oe)
        else $error("write qualifier driven without address");
    inq_pulse_a: assert property (!inquire_strobe_n |-> bus_hold_ack ##1 inquire_strobe_n)
        else $error("inquire strobe outside hold or too long");
    hold_idle_a: assert property ($rose(bus_hold_req) |-> burst_rdy_n)
        else $error("hold requested during burst");
    a20_reset_a: assert property (proc_reset |-> addr20_mask_n)
        else $error("address mask active during processor reset");
endmodule
`default_nettype wire

// *** tb/host_cpu_bus_interface_test.sv ***
// testbench: bridge and processor ends joined, random and corner cycles
`timescale 1ns/100ps
`default_nettype none
module host_cpu_bus_interface_test;
    import hcb_pkg::*;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic [28:0]    top = 29'h0000_FFFF;
    logic [28:0]    pci_addr = 29'h0;
    logic [28:0]    snp_addr = 29'h0;
    logic [28:0]    req_addr = 29'h0;
    logic [7:0]     req_lanes = 8'h0;
    logic           pci_req = 1'b0, pci_wr = 1'b0, snp_req = 1'b0, a20 = 1'b0, prst = 1'b0;
    logic           pinit = 1'b0, smi = 1'b0, stop = 1'b0, req = 1'b0, req_mem = 1'b0;
    logic           req_wr = 1'b0, req_code = 1'b0, req_cache = 1'b0, dirty = 1'b0, smm = 1'b0;
    logic           c_valid, c_wr, c_code, grant, s_dirty, smm_act, rdy, held, rst_seen;
    hcb_target_type c_tgt;
    logic [28:0]    c_addr;
    logic [7:0]     c_lanes;
    logic [15:0]    r = 16'h0015;
    int             error_cnt = 0;
    int             n_compared = 0;
    hcb_if hbus ();
    hcb_bridge i_hcb_bridge (.CLK_IN(clk), .RST_N_IN(rst_n), .bus(hbus), .DRAM_TOP_IN(top),
        .PCI_REQ_IN(pci_req), .PCI_ADDR_IN(pci_addr), .PCI_WRITE_IN(pci_wr),
        .SNOOP_REQ_IN(snp_req), .SNOOP_ADDR_IN(snp_addr), .A20_MASK_IN(a20),
        .PROC_RESET_IN(prst), .PROC_INIT_IN(pinit), .SMI_EVENT_IN(smi), .STOP_CLOCK_IN(stop),
        .CYCLE_VALID_OUT(c_valid), .CYCLE_TARGET_OUT(c_tgt), .CYCLE_ADDR_OUT(c_addr),
        .CYCLE_WRITE_OUT(c_wr), .CYCLE_CODE_OUT(c_code), .CYCLE_LANES_OUT(c_lanes),
        .PCI_GRANT_OUT(grant), .SNOOP_DIRTY_OUT(s_dirty), .SMM_ACTIVE_OUT(smm_act));
    hcb_proc i_hcb_proc (.CLK_IN(clk), .RST_N_IN(rst_n), .bus(hbus), .REQ_IN(req),
        .REQ_ADDR_IN(req_addr), .REQ_LANES_IN(req_lanes), .REQ_MEM_IN(req_mem),
        .REQ_WRITE_IN(req_wr), .REQ_CODE_IN(req_code), .REQ_CACHE_IN(req_cache),
        .SNOOP_DIRTY_IN(dirty), .SMM_IN(smm), .REQ_READY_OUT(rdy), .BEAT_OUT(),
        .HELD_OUT(held), .RESET_SEEN_OUT(rst_seen));
    hcb_props i_props (.CLK_IN(clk), .RST_N_IN(rst_n), .cycle_strobe_n(hbus.cycle_strobe_n),
        .mem_io(hbus.mem_io), .cache_ind_n(hbus.cache_ind_n), .burst_rdy_n(hbus.burst_rdy_n),
        .next_cycle_ok_n(hbus.next_cycle_ok_n), .l1_cacheable_n(hbus.l1_cacheable_n),
        .inquire_strobe_n(hbus.inquire_strobe_n), .bus_hold_req(hbus.bus_hold_req),
        .bus_hold_ack(hbus.bus_hold_ack), .addr_dev_oe(hbus.addr_dev_oe),
        .wr_dev_oe(hbus.wr_dev_oe), .addr20_mask_n(hbus.addr20_mask_n),
        .proc_reset(hbus.proc_reset));
    // 100 MHz clock
    always #5 clk = ~clk;
    // pseudo random step
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // expected route of a cycle
    function automatic hcb_target_type exp_tgt(input logic m, input logic [28:0] a);
        if (m !== 1'b1) return HCB_TGT_IO;
        return (a <= top) ? HCB_TGT_DRAM : HCB_TGT_PCI;
    endfunction
    // count and report one comparison
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // one processor cycle, checked at the decode side
    task automatic cyc(input logic [28:0] a, input logic [15:0] v);
        @(negedge clk);
        req = 1'b1;
        req_addr = a;
        req_lanes = v[7:0];
        req_mem = v[8];
        req_wr = v[9];
        req_code = v[10];
        req_cache = v[11];
        repeat (50) if (rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
        req = 1'b0;
        repeat (20) if (c_valid !== 1'b1) @(negedge clk);
        chk(c_valid === 1'b1, "no decoded cycle");
        chk(c_tgt === exp_tgt(v[8], a), "wrong target");
        chk(c_addr === a, "wrong address");
        chk({c_wr, c_code} === {v[9], v[10]}, "wrong qualifiers");
        chk(hbus.l1_cacheable_n === ~(v[11] & ~v[9] & v[8] & (a <= top)), "cache hint");
        chk(c_lanes === v[7:0], "wrong lanes");
    endtask
    // end of run with verdict
    task automatic end_sim;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk({hbus.burst_rdy_n, hbus.next_cycle_ok_n, hbus.inquire_strobe_n, hbus.addr20_mask_n,
            hbus.sysmgmt_irq_n, hbus.clock_stop_req_n, hbus.bus_hold_req, hbus.proc_reset,
            hbus.addr_dev_oe} === 9'h1F8, "outputs not idle after reset");
        cyc(29'h0000_FFFF, 16'h0B5A);
        cyc(29'h0001_0000, 16'h0B5A);
        cyc(29'h0000_0000, 16'h0481);
        for (int i = 0; i < 24; i++) begin
            r = lfsr(r);
            cyc({12'h000, r[15:14] == 2'h0, r}, lfsr(r));
        end
        repeat (10) @(negedge clk);
        pci_req = 1'b1;
        pci_addr = 29'h0ABC_1234;
        pci_wr = 1'b1;
        repeat (30) if (grant !== 1'b1) @(negedge clk);
        chk(grant === 1'b1 && held === 1'b1, "hold not granted");
        chk({hbus.addr_dev, hbus.wr_dev, hbus.wr_dev_oe} === {pci_addr, 2'h3}, "bad drive");
        pci_req = 1'b0;
        repeat (30) if (grant !== 1'b0) @(negedge clk);
        chk(grant === 1'b0, "hold not released");
        snp_req = 1'b1;
        snp_addr = 29'h1234_5678;
        dirty = 1'b1;
        repeat (30) if (hbus.inquire_strobe_n !== 1'b0) @(negedge clk);
        chk(hbus.inquire_strobe_n === 1'b0 && hbus.addr_dev === snp_addr, "no inquire");
        repeat (4) @(negedge clk);
        chk(s_dirty === 1'b1, "snoop hit not seen");
        snp_req = 1'b0;
        dirty = 1'b0;
        {a20, stop, smi, smm, pinit} = 5'h1F;
        repeat (30) @(negedge clk);
        chk({hbus.addr20_mask_n, hbus.clock_stop_req_n, hbus.sysmgmt_irq_n} === 3'h0, "side");
        chk({smm_act, hbus.proc_init} === 2'h3, "smm or init not seen");
        prst = 1'b1;
        repeat (4) @(negedge clk);
        chk({hbus.proc_reset, hbus.addr20_mask_n, rst_seen} === 3'h7, "reset wrong");
        {a20, stop, smi, smm, pinit, prst} = 6'h00;
        repeat (4) @(negedge clk);
        chk({hbus.proc_reset, hbus.clock_stop_req_n, smm_act} === 3'h2, "not cleared");
        end_sim();
    end
endmodule
`default_nettype wire
